// ### src/rut_pkg.sv
package rut_pkg;

	// register byte offsets within the block
	localparam logic [11:0] RUT_OFS_SWRST = 12'ha40;
	localparam logic [11:0] RUT_OFS_UNLOCK = 12'ha5c;
	localparam logic [11:0] RUT_OFS_TRIM = 12'ha6c;
	localparam logic [11:0] RUT_OFS_STATUS = 12'ha70;

	// unlock value and field layout
	localparam logic [15:0] RUT_UNLOCK_VALUE = 16'h12ea;
	localparam int RUT_TRIM_MSB = 3;
	localparam int RUT_STATUS_OPEN_BIT = 0;

	// values after reset
	localparam logic [15:0] RUT_RST_UNLOCK = 16'h0000;
	localparam logic [15:0] RUT_RST_TRIM = 16'h0088;
	localparam logic [15:0] RUT_RST_SWRST = 16'h0000;
	localparam logic [31:0] RUT_RST_RDATA = 32'h0000_0000;
	localparam logic [11:0] RUT_RST_ADDR = 12'h000;

	// ahb transfer type bits and response
	localparam logic [1:0] RUT_HTRANS_NONSEQ = 2'h2;
	localparam logic RUT_HRESP_OKAY = 1'h0;

	// protection state of the software reset control register
	typedef enum logic [0:0]
	{
		RUT_LOCKED = 1'b0,
		RUT_OPEN = 1'b1
	} rut_lock_t;

	// address phase as the slave captures it
	typedef struct packed
	{
		logic take;
		logic write;
		logic [11:0] addr;
	} rut_req_t;

	// whole state of the block
	typedef struct packed
	{
		rut_lock_t lock;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [15:0] unlock_code;
		logic [15:0] trim;
		logic [15:0] swrst;
		logic [31:0] rdata;
	} rut_state_t;

endpackage

// ### src/rut_top.sv
// Overview of operation
// - control register locked until key 0x12ea written
// - any other register write relocks the protection
// - key is write-only sixteen bits, resets zero
// - sixteen-bit trim register, read/write, resets to 0x0088; low four bits drive trim_out
`timescale 1ns/1ps
`default_nettype none

module rut_top
	import rut_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite address phase
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	// ahb-lite data phase
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// towards the oscillator and reset logic
	output logic [RUT_TRIM_MSB:0] trim_out,
	output logic [15:0] swrst_ctrl,
	output logic unlocked
);

	rut_state_t s_r;
	rut_state_t s_nxt;
	rut_req_t req;
	logic dp_key;
	logic dp_trim;
	logic dp_swrst;
	logic [15:0] trim_view;
	logic [15:0] swrst_view;
	rut_lock_t lock_view;

	// hready gates the capture so a stalled bus never starts a second transfer
	// address phase capture; only word transfers are expected, so hsize is not decoded
	always_comb
	begin
		req.take = hsel & hready & htrans[1];
		req.write = hwrite;
		req.addr = {haddr[11:2], 2'b00};
	end

	// reads load wr_addr too, but wr_pend masks them out of the decode
	// decode of the write that is in its data phase
	assign dp_key = (s_r.wr_addr == RUT_OFS_UNLOCK);
	assign dp_trim = (s_r.wr_addr == RUT_OFS_TRIM);
	assign dp_swrst = (s_r.wr_addr == RUT_OFS_SWRST);

	// the lock is judged on data-phase writes only; reads pass it through
	// a refused control write still relocks, so a stray write never leaves it open
	// register values with the pending write folded in, so a read right behind a write sees new data
	always_comb
	begin
		trim_view = s_r.trim;
		swrst_view = s_r.swrst;
		lock_view = s_r.lock;
		if (s_r.wr_pend)
		begin
			if (dp_trim)
			begin
				trim_view = hwdata[15:0];
			end
			if (dp_swrst)
			begin
				if (s_r.lock == RUT_OPEN)
				begin
					swrst_view = hwdata[15:0];
				end
				lock_view = RUT_LOCKED;
			end
			else if (dp_key)
			begin
				lock_view = (hwdata[15:0] == RUT_UNLOCK_VALUE) ? RUT_OPEN : RUT_LOCKED;
			end
			else
			begin
				lock_view = RUT_LOCKED;
			end
		end
	end

	// rdata is zero outside a read data phase, so idle cycles leak nothing
	// limitation: no wait states, a read behind a write relies on the forwarding above
	// next state: writes land in the data phase, reads are answered from the address phase
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.trim = trim_view;
		s_nxt.swrst = swrst_view;
		s_nxt.lock = lock_view;
		if (s_r.wr_pend && dp_key)
		begin
			s_nxt.unlock_code = hwdata[15:0];
		end
		s_nxt.wr_pend = req.take & req.write;
		s_nxt.wr_addr = req.take ? req.addr : RUT_RST_ADDR;
		if (req.take && !req.write)
		begin
			// reads never touch the lock state
			case (req.addr)
				RUT_OFS_UNLOCK: s_nxt.rdata = 32'h0000_0000;
				RUT_OFS_TRIM: s_nxt.rdata = {16'h0000, trim_view};
				RUT_OFS_SWRST: s_nxt.rdata = {16'h0000, swrst_view};
				RUT_OFS_STATUS: s_nxt.rdata = {31'h0000_0000, lock_view == RUT_OPEN};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		else
		begin
			s_nxt.rdata = 32'h0000_0000;
		end
	end

	// the lock always starts closed after reset
	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r.lock <= RUT_LOCKED;
			s_r.wr_pend <= 1'b0;
			s_r.wr_addr <= RUT_RST_ADDR;
			s_r.unlock_code <= RUT_RST_UNLOCK;
			s_r.trim <= RUT_RST_TRIM;
			s_r.swrst <= RUT_RST_SWRST;
			s_r.rdata <= RUT_RST_RDATA;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// swrst_ctrl feeds the reset logic directly and moves only on an unlocked write
	// outputs; zero wait states, never an error
	assign hrdata = s_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = RUT_HRESP_OKAY;
	assign trim_out = s_r.trim[RUT_TRIM_MSB:0];
	assign swrst_ctrl = s_r.swrst;
	assign unlocked = (s_r.lock == RUT_OPEN);

	// checks on the protection sequence and the registers
	// all checks share hclk and rest while hresetn is low
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// helper: a read of the key register entering its data phase
	logic key_rd;
	assign key_rd = req.take & !req.write & (req.addr == RUT_OFS_UNLOCK);

	// helpers: key or control write in its data phase, and any read being taken
	logic key_wr;
	logic ctl_wr;
	logic rd_take;
	assign key_wr = s_r.wr_pend & dp_key;
	assign ctl_wr = s_r.wr_pend & dp_swrst;
	assign rd_take = req.take & !req.write;

	stay_locked_a: assert property ((!unlocked && !(s_r.wr_pend && dp_key && hwdata[15:0] == RUT_UNLOCK_VALUE))
		|=> !unlocked)
		else $error("lock opened without the unlock value");

	key_opens_a: assert property ((s_r.wr_pend && dp_key && hwdata[15:0] == RUT_UNLOCK_VALUE)
		|=> unlocked)
		else $error("unlock value did not open the lock");

	locked_write_a: assert property ((s_r.wr_pend && dp_swrst && !unlocked) |=> $stable(swrst_ctrl))
		else $error("control register changed while locked");

	open_write_a: assert property ((s_r.wr_pend && dp_swrst && unlocked)
		|=> (swrst_ctrl == $past(hwdata[15:0])) && !unlocked)
		else $error("unlocked control write not taken or lock kept");

	other_relocks_a: assert property ((s_r.wr_pend && !dp_key && !dp_swrst) |=> !unlocked)
		else $error("write elsewhere did not relock");

	key_store_a: assert property ((s_r.wr_pend && dp_key) |=> s_r.unlock_code == $past(hwdata[15:0]))
		else $error("key field not stored");

	key_read_a: assert property (key_rd |=> hrdata == 32'h0000_0000)
		else $error("key register read not zero");

	read_keeps_a: assert property (!s_r.wr_pend |=> $stable(unlocked))
		else $error("lock changed without a write");

	trim_write_a: assert property ((s_r.wr_pend && dp_trim) |=> trim_out == $past(hwdata[3:0]))
		else $error("trim write not applied");

	trim_hold_a: assert property (!(s_r.wr_pend && dp_trim) |=> $stable(trim_out))
		else $error("trim changed without a write");

	// protection sequence: what may open, keep and close the lock
	// the lock opens only on a key write
	open_cause_a: assert property ($rose(unlocked)
		|-> $past(key_wr))
		else $error("lock opened without a key write");

	// a wrong key leaves it closed
	wrong_key_a: assert property ((key_wr && hwdata[15:0] != RUT_UNLOCK_VALUE)
		|=> !unlocked)
		else $error("wrong key opened the lock");

	// the lock closes only on a write
	relock_cause_a: assert property ($fell(unlocked)
		|-> $past(s_r.wr_pend))
		else $error("lock closed without a write");

	// a trim write relocks
	trim_relocks_a: assert property ((s_r.wr_pend && dp_trim)
		|=> !unlocked)
		else $error("trim write left the lock open");

	// any control write relocks, taken or refused
	ctrl_relocks_a: assert property (ctl_wr
		|=> !unlocked)
		else $error("control write left the lock open");

	// control value moves only on an unlocked control write
	ctrl_cause_a: assert property ($changed(swrst_ctrl)
		|-> $past(ctl_wr) && $past(unlocked))
		else $error("control register changed without an unlocked write");

	// control value holds without a control write
	ctrl_hold_a: assert property (!ctl_wr
		|=> $stable(swrst_ctrl))
		else $error("control register changed without a write");

	// key field holds without a key write
	key_hold_a: assert property (!key_wr
		|=> $stable(s_r.unlock_code))
		else $error("key field changed without a key write");

	// key reads never open or close the lock
	key_rd_keeps_a: assert property ((key_rd && !s_r.wr_pend)
		|=> $stable(unlocked))
		else $error("key read changed the lock");

	// a key read never turns into a write
	key_rd_nopend_a: assert property (key_rd
		|=> !s_r.wr_pend)
		else $error("key read left a write pending");

	// the whole trim word is stored
	trim_full_a: assert property ((s_r.wr_pend && dp_trim)
		|=> s_r.trim == $past(hwdata[15:0]))
		else $error("trim word not stored");

	// bus housekeeping: captured address phase and read data
	// trim reads show the register
	trim_read_a: assert property ((rd_take && req.addr == RUT_OFS_TRIM)
		|=> hrdata == {16'h0000, s_r.trim})
		else $error("trim read wrong");

	// control reads show the register
	ctrl_read_a: assert property ((rd_take && req.addr == RUT_OFS_SWRST)
		|=> hrdata == {16'h0000, swrst_ctrl})
		else $error("control read wrong");

	// status bit 0 follows the lock
	status_read_a: assert property ((rd_take && req.addr == RUT_OFS_STATUS)
		|=> hrdata == {31'h0000_0000, unlocked})
		else $error("status read wrong");

	// unmapped reads return zero
	unmapped_read_a: assert property ((rd_take && req.addr != RUT_OFS_UNLOCK && req.addr != RUT_OFS_TRIM
		&& req.addr != RUT_OFS_SWRST && req.addr != RUT_OFS_STATUS)
		|=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// read data is zero outside a read data phase
	idle_rdata_a: assert property (!rd_take
		|=> hrdata == 32'h0000_0000)
		else $error("read data outside a read");

	// upper half of every read is zero
	upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");

	// a taken write is pending in the next cycle
	pend_capture_a: assert property ((req.take && req.write)
		|=> s_r.wr_pend)
		else $error("taken write not pending");

	// nothing else leaves a write pending
	pend_clear_a: assert property (!(req.take && req.write)
		|=> !s_r.wr_pend)
		else $error("write pending without a taken write");

	// the taken address is held for the data phase
	addr_capture_a: assert property (req.take
		|=> s_r.wr_addr == $past(req.addr))
		else $error("address phase not captured");

endmodule

`default_nettype wire

// ### test/rut_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end

module rut_top_tb
	import rut_pkg::*;
;
	// bus side and block outputs
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic hreadyout;
	logic hresp;
	logic unlocked;
	logic [RUT_TRIM_MSB:0] trim_out;
	logic [15:0] swrst_ctrl;
	logic [15:0] ctl_exp;
	logic [15:0] trim_exp;
	logic [15:0] v;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;

	// 200 mhz clock
	always #2.5 hclk = ~hclk;

	rut_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .trim_out(trim_out), .swrst_ctrl(swrst_ctrl), .unlocked(unlocked));

	// hang guard, far above the few hundred cycles needed
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			summarize();
		end
	end

	function automatic logic [3:0] trim_of(input logic [15:0] r);
		return r[3:0];
	endfunction

	task summarize;
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one single transfer; hready is sampled at rising edges, read data taken at the closing edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= RUT_HTRANS_NONSEQ;
		hwrite <= wr;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		`CHK("hresp", RUT_HRESP_OKAY, hresp)
	endtask

	// outputs and readback against the expected register contents
	task automatic check_all;
		@(negedge hclk);
		`CHK("swrst_ctrl", ctl_exp, swrst_ctrl)
		`CHK("trim_out", trim_of(trim_exp), trim_out)
		`CHK("unlocked", 1'b0, unlocked)
		`CHK("hreadyout", 1'b1, hreadyout)
		@(posedge hclk);
		bus(1'b0, RUT_OFS_TRIM, 32'h0, q);
		`CHK("trim read", {16'h0, trim_exp}, q)
		bus(1'b0, RUT_OFS_UNLOCK, 32'h0, q);
		`CHK("key read", 32'h0, q)
		bus(1'b0, RUT_OFS_SWRST, 32'h0, q);
		`CHK("ctrl read", {16'h0, ctl_exp}, q)
		bus(1'b0, RUT_OFS_STATUS, 32'h0, q);
		`CHK("status read", 32'h0, q)
	endtask

	initial
	begin
		void'($urandom(96));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		ctl_exp = RUT_RST_SWRST;
		trim_exp = RUT_RST_TRIM;
		check_all();
		bus(1'b1, RUT_OFS_SWRST, $urandom, q);
		check_all();
		// i 0 wrong key; then plain, key read, trim between, unmapped between
		for (int i = 0; i < 12; i++)
		begin
			v = 16'($urandom);
			bus(1'b1, RUT_OFS_UNLOCK, {16'h0, RUT_UNLOCK_VALUE ^ ((i == 0) ? 16'h0001 : 16'h0)}, q);
			case (i % 4)
				1:
				begin
					bus(1'b0, RUT_OFS_UNLOCK, 32'h0, q);
					`CHK("key read open", 32'h0, q)
					bus(1'b0, RUT_OFS_STATUS, 32'h0, q);
					`CHK("status open", 32'h1, q)
					@(negedge hclk);
					`CHK("unlocked", 1'b1, unlocked)
					@(posedge hclk);
				end
				2:
				begin
					bus(1'b1, RUT_OFS_TRIM, {16'($urandom), v}, q);
					trim_exp = v;
				end
				3:
				begin
					bus(1'b0, 12'h100, 32'h0, q);
					`CHK("unmapped read", 32'h0, q)
					bus(1'b1, 12'h100, {16'h0, v}, q);
				end
				default: ;
			endcase
			bus(1'b1, RUT_OFS_SWRST, {16'h0, v}, q);
			if (i % 4 < 2 && i != 0)
				ctl_exp = v;
			// a second control write must find it locked again
			bus(1'b1, RUT_OFS_SWRST, {16'h0, ~v}, q);
			check_all();
		end
		// reset in mid-run restores every register; open the lock first so reset must close it
		bus(1'b1, RUT_OFS_UNLOCK, {16'h0, RUT_UNLOCK_VALUE}, q);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		ctl_exp = RUT_RST_SWRST;
		trim_exp = RUT_RST_TRIM;
		check_all();
		summarize();
	end
endmodule

`default_nettype wire
